// *** design/ans_nibble_stacker.sv ***
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
// Behaviour
// (RULE1) Twelve serial bits: eight sample, four zero
// (RULE2) Sample bits shifted out msb first
// (RULE3) One gated 447 kHz clock, twelve states
// (RULE4) Bit counter stops clock at 1100
// (RULE5) Gate passes clock only when enabled
// (RULE6) Codec shifts twelve serial bits in
// (RULE7) Codec then presents a 4-bit nibble
// (RULE8) Codec start output starts the converter
// (RULE9) Two codec nibbles merge into one byte
// (RULE10) Latches sequenced by codec sample clock
// (RULE11) Rate select 01 is 6k, 10 8k
// (RULE12) First sample edge holds nibble, sets phase
// (RULE13) Next edge strobes both nibbles into byte
// (RULE14) Packed byte read at address 10h
// (RULE15) Host moves each byte by DMA
// (RULE16) Upper strobe sets the byte-ready interrupt
// (RULE17) Write to 10h clears the interrupt
// (RULE18) Decode write to 10h latches byte
// (RULE19) Decode low phase drives lower nibble
// (RULE20) Next sample edge drives upper nibble
// (RULE21) Decode drivers stay off while encoding
// (RULE22) Codec reset input reinitialises codec
// (RULE23) Halt bit resets codec, read control
// (RULE24) Number format select held high
// (RULE25) Phase returns low after each byte
// (RULE26) Stored decode byte stable until delivered
module ans_nibble_stacker (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rstn,
    // APB slave
    input  wire ans_pkg::ans_apb_req_t apbReq,
    output ans_pkg::ans_apb_rsp_t      apbRsp,
    output logic                       byteReadyIrqN,
    // Codec
    input  wire logic                  sampleRateClock,
    input  wire logic                  conversionBeginOutN,
    input  wire logic [3:0]            vocoderNibbleIn,
    output logic [3:0]                 vocoderNibbleOut,
    output logic                       vocoderNibbleOeN,
    output logic                       lowerNibbleOutputEnableN,
    output logic                       upperNibbleOutputEnableN,
    output logic                       analyzeSynthesizeSelect,
    output logic                       rateSelectA,
    output logic                       rateSelectB,
    output logic                       numberFormatSelect,
    output logic                       codecReset,
    output logic                       serialPcmClock,
    output logic                       serialPcmInput,
    // Converter
    input  wire logic                  adcEndN,
    input  wire logic [7:0]            adcData,
    output logic                       adcStartN,
    output logic                       adcReadN
);
    import ans_pkg::*;

    localparam logic [1:0] RD_LAST = 2'(RD_SETTLE - 1);

    typedef struct packed {
        logic        rateS1;
        logic        rateS2;
        logic        rateD;
        logic        convS1;
        logic        convS2;
        logic        endS1;
        logic        endS2;
        logic        endD;
        logic [3:0]  nibS1;
        logic [3:0]  nibS2;
        logic [7:0]  adcS1;
        logic [7:0]  adcS2;
        logic [7:0]  lineCtl;
        logic        adcRd;
        logic [1:0]  rdCnt;
        logic        odd;
        logic [3:0]  holdNib;
        logic [7:0]  byteOut;
        logic [7:0]  decByte;
        logic [7:0]  pendByte;
        logic        pendValid;
        logic        ldh;
        logic        irqSet;
        logic        irq;
        logic [3:0]  nibOut;
        logic [31:0] prdata;
    } ans_state_t;

    ans_state_t s;
    ans_state_t n;

    logic        halt;
    logic        analyze;
    logic        rateRise;
    logic        endFall;
    logic        setupPh;
    logic        accessPh;
    logic        mapped;
    logic        wrAcc;
    logic        dataWr;
    logic        adcLoad;
    logic        serBusy;
    logic [11:0] frameBits;

    assign halt     = s.lineCtl[LC_HALT];
    assign analyze  = s.lineCtl[LC_ANALYZE];
    assign rateRise = s.rateS2 && !s.rateD;                          // [RULE10]
    assign endFall  = !s.endS2 && s.endD;
    assign setupPh  = apbReq.psel && !apbReq.penable;
    assign accessPh = apbReq.psel && apbReq.penable;
    assign mapped   = (apbReq.paddr == OFS_DATA) || (apbReq.paddr == OFS_STATUS)
                   || (apbReq.paddr == OFS_FRAME) || (apbReq.paddr == OFS_LINECTL);
    assign wrAcc    = accessPh && apbReq.pwrite && mapped;
    assign dataWr   = wrAcc && (apbReq.paddr == OFS_DATA);
    assign adcLoad  = s.adcRd && (s.rdCnt == RD_LAST) && !serBusy;

    always_comb begin
        n = s;
        // Pin synchronisers
        n.rateS1 = sampleRateClock;
        n.rateS2 = s.rateS1;
        n.rateD  = s.rateS2;
        n.convS1 = conversionBeginOutN;
        n.convS2 = s.convS1;
        n.endS1  = adcEndN;
        n.endS2  = s.endS1;
        n.endD   = s.endS2;
        n.nibS1  = vocoderNibbleIn;
        n.nibS2  = s.nibS1;
        n.adcS1  = adcData;
        n.adcS2  = s.adcS1;
        n.ldh    = 1'b0;
        n.irqSet = 1'b0;
        n.prdata = 32'h0000_0000;

        // Converter read control: strobe read at end of conversion, hold until loaded (third cycle at the earliest)
        if (halt || !analyze) begin
            n.adcRd = 1'b0;                                          // [RULE23]
            n.rdCnt = 2'h0;
        end else if (!s.adcRd) begin
            if (endFall) begin
                n.adcRd = 1'b1;
                n.rdCnt = 2'h0;
            end
        end else if (s.rdCnt != RD_LAST) begin
            n.rdCnt = s.rdCnt + 2'h1;
        end else if (adcLoad) begin
            n.adcRd = 1'b0;
        end

        // Nibble pairing on the codec sample clock
        if (halt) begin
            n.odd       = 1'b0;                                      // [RULE23]
            n.pendValid = 1'b0;
        end else if (rateRise) begin
            if (analyze) begin
                if (!s.odd) begin
                    n.holdNib = s.nibS2;                             // [RULE7] [RULE12]
                    n.odd     = 1'b1;                                // [RULE12]
                end else begin
                    n.byteOut = {s.nibS2, s.holdNib};                // [RULE9] [RULE13]
                    n.odd     = 1'b0;                                // [RULE25]
                    n.ldh     = 1'b1;                                // [RULE13]
                end
            end else if (!s.odd) begin
                n.odd = 1'b1;                                        // [RULE20]
            end else begin
                n.odd    = 1'b0;                                     // [RULE25]
                n.irqSet = 1'b1;
                if (s.pendValid) begin
                    n.decByte   = s.pendByte;                        // [RULE26]
                    n.pendValid = 1'b0;
                end
            end
        end

        // Decode byte from the microcontroller
        if (dataWr && !analyze && !halt) begin
            if (!n.odd) begin
                n.decByte = apbReq.pwdata[7:0];                      // [RULE18]
            end else begin
                n.pendByte  = apbReq.pwdata[7:0];                    // [RULE26]
                n.pendValid = 1'b1;
            end
        end

        // Interrupt: strobe sets, acknowledge clears, set wins
        if (s.ldh) begin
            n.irqSet = 1'b1;                                         // [RULE16]
        end
        n.irq = (s.irq && !dataWr) || s.irqSet;                      // [RULE16] [RULE17]

        n.nibOut = n.odd ? n.decByte[7:4] : n.decByte[3:0];          // [RULE19] [RULE20]

        // Register writes
        if (wrAcc && (apbReq.paddr == OFS_LINECTL)) begin
            n.lineCtl = apbReq.pwdata[7:0];                          // [RULE23]
        end

        // Read data captured in the setup cycle, shown in the access cycle
        if (setupPh && !apbReq.pwrite) begin
            unique case (apbReq.paddr)
                OFS_DATA: begin
                    n.prdata = {24'h00_0000, s.byteOut};             // [RULE14]
                end
                OFS_STATUS: begin
                    n.prdata[ST_IRQ]  = s.irq;
                    n.prdata[ST_ODD]  = s.odd;
                    n.prdata[ST_BUSY] = serBusy;
                    n.prdata[ST_PEND] = s.pendValid;
                end
                OFS_FRAME: begin
                    n.prdata = {20'h0_0000, frameBits};
                end
                OFS_LINECTL: begin
                    n.prdata = {24'h00_0000, s.lineCtl};
                end
                default: begin
                    n.prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s         <= '0;
            s.rateS1  <= 1'b0;
            s.convS1  <= 1'b1;
            s.convS2  <= 1'b1;
            s.endS1   <= 1'b1;
            s.endS2   <= 1'b1;
            s.endD    <= 1'b1;
            s.lineCtl <= LINECTL_RST;
        end else begin
            s <= n;
        end
    end

    ans_serial_framer #(
        .DIV            (SER_DIV)
    ) uFramer (
        .ref_clk        (ref_clk),
        .rstn           (rstn),
        .halt           (halt),
        .load           (adcLoad),                                   // [RULE3]
        .sampleData     (s.adcS2),
        .busy           (serBusy),
        .frameBits      (frameBits),
        .serialPcmClock (serialPcmClock),
        .serialPcmInput (serialPcmInput)
    );

    // APB answer: no wait states
    assign apbRsp.pready  = 1'b1;
    assign apbRsp.prdata  = s.prdata;
    assign apbRsp.pslverr = accessPh && !mapped;

    // Codec and converter pins
    assign byteReadyIrqN            = !s.irq;                        // [RULE16]
    assign vocoderNibbleOut         = s.nibOut;
    assign vocoderNibbleOeN         = analyze || halt;               // [RULE21]
    assign lowerNibbleOutputEnableN = analyze || halt || s.odd;      // [RULE19] [RULE21]
    assign upperNibbleOutputEnableN = analyze || halt || !s.odd;     // [RULE20] [RULE21]
    assign analyzeSynthesizeSelect  = analyze;
    assign rateSelectA              = s.lineCtl[LC_RATE8K];          // [RULE11]
    assign rateSelectB              = !s.lineCtl[LC_RATE8K];         // [RULE11]
    assign numberFormatSelect       = 1'b1;                          // [RULE24]
    assign codecReset               = halt;                          // [RULE22] [RULE23]
    assign adcStartN                = s.convS2;                      // [RULE8]
    assign adcReadN                 = !s.adcRd;

    AST_IRQ_SET: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE16]
        s.ldh |-> ##2 !byteReadyIrqN)
        else $error("upper strobe did not raise byte-ready interrupt");

    AST_IRQ_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE17]
        (dataWr && !s.irqSet) |=> byteReadyIrqN)
        else $error("acknowledge write did not clear interrupt");

    AST_FIRST_NIBBLE: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE12]
        (rateRise && analyze && !s.odd && !halt) |=> s.odd && s.holdNib == $past(s.nibS2))
        else $error("first nibble not held");

    AST_PACK_BYTE: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE13]
        (rateRise && analyze && s.odd && !halt)
        |=> s.ldh && !s.odd && s.byteOut == {$past(s.nibS2), $past(s.holdNib)})
        else $error("byte not packed from both nibbles");

    AST_ENCODE_QUIET: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE21]
        analyze |-> vocoderNibbleOeN && lowerNibbleOutputEnableN && upperNibbleOutputEnableN)
        else $error("decode drivers enabled while encoding");

    AST_HALT_CLEARS: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE23]
        halt |-> codecReset ##1 (!s.odd && !s.adcRd))
        else $error("halt did not clear read control and phase");

    AST_RATE_PATTERN: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE11]
        rateSelectA != rateSelectB)
        else $error("illegal rate select pattern");

    AST_DEC_STABLE: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE26]
        (s.odd && !analyze && !halt && !rateRise) |=> $stable(s.decByte))
        else $error("decode byte changed mid delivery");

    AST_DEC_LOWER: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE19]
        (!analyze && !halt && !s.odd) |-> !lowerNibbleOutputEnableN
        && vocoderNibbleOut == s.decByte[3:0])
        else $error("lower nibble not driven in low phase");

    AST_DEC_UPPER: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE20]
        (!analyze && !halt && s.odd) |-> !upperNibbleOutputEnableN && lowerNibbleOutputEnableN
        && vocoderNibbleOut == s.decByte[7:4])
        else $error("upper nibble not driven in high phase");

    AST_DEC_STORE: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE18]
        (dataWr && !analyze && !halt && !s.odd && !rateRise)
        |=> s.decByte == $past(apbReq.pwdata[7:0]))
        else $error("decode write not latched");

    AST_PHASE_RETURN: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE25]
        (rateRise && !halt && s.odd) |=> !s.odd)
        else $error("phase did not return low after byte");

    AST_READ_DATA: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE14]
        (accessPh && !apbReq.pwrite && apbReq.paddr == OFS_DATA)
        |-> apbRsp.prdata == {24'h00_0000, $past(s.byteOut)})
        else $error("packed byte not returned on data read");

    AST_READ_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE14]
        !(accessPh && !apbReq.pwrite) |-> apbRsp.prdata == 32'h0000_0000)
        else $error("read data driven outside a read");

    AST_IRQ_STANDS: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE16]
        (!byteReadyIrqN && !dataWr) |=> !byteReadyIrqN)
        else $error("byte-ready interrupt dropped without acknowledge");

    AST_SER_LOAD: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE3]
        (adcLoad && !halt) |=> serBusy)
        else $error("serial clock gate did not open on load");

endmodule

// *** design/ans_pkg.sv ***
package ans_pkg;

    // Timing
    localparam int unsigned CLK_HZ      = 100_000_000;
    localparam int unsigned SER_CLK_HZ  = 447_000;
    localparam int unsigned SER_DIV     = CLK_HZ / SER_CLK_HZ;
    localparam int unsigned SER_HALF    = SER_DIV / 2;
    localparam int unsigned RD_SETTLE   = 3;

    // Serial frame
    localparam int unsigned SAMPLE_BITS = 8;
    localparam int unsigned FRAME_BITS  = 12;
    localparam logic [3:0]  FRAME_END   = 4'hc;

    // Register offsets
    localparam logic [7:0]  OFS_DATA    = 8'h10;
    localparam logic [7:0]  OFS_STATUS  = 8'h14;
    localparam logic [7:0]  OFS_FRAME   = 8'h18;
    localparam logic [7:0]  OFS_LINECTL = 8'ha0;

    // Line control fields
    localparam int unsigned LC_ANALYZE  = 0;
    localparam int unsigned LC_RATE8K   = 1;
    localparam int unsigned LC_HALT     = 5;
    localparam logic [7:0]  LINECTL_RST = 8'h00;

    // Status fields
    localparam int unsigned ST_IRQ      = 0;
    localparam int unsigned ST_ODD      = 1;
    localparam int unsigned ST_BUSY     = 2;
    localparam int unsigned ST_PEND     = 3;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } ans_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } ans_apb_rsp_t;

    typedef struct packed {
        logic [7:0]  div;
        logic        gate;
        logic        sck;
        logic [3:0]  bitCnt;
        logic [7:0]  shift;
        logic [11:0] frame;
    } ans_ser_state_t;

endpackage

// *** design/ans_serial_framer.sv ***
`timescale 1ns/1ps
module ans_serial_framer #(
    parameter int unsigned DIV = ans_pkg::SER_DIV
) (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // Control
    input  wire logic       halt,
    input  wire logic       load,
    input  wire logic [7:0] sampleData,
    output logic            busy,
    output logic [11:0]     frameBits,
    // Serial pins
    output logic            serialPcmClock,
    output logic            serialPcmInput
);
    import ans_pkg::*;

    localparam logic [7:0] DIV_LAST  = 8'(DIV - 1);
    localparam logic [7:0] HALF_MARK = 8'(DIV / 2);

    if (DIV < 2 || DIV > 256) begin : gBadDiv
        $error("ans_serial_framer: DIV out of range");
    end

    ans_ser_state_t s;
    ans_ser_state_t n;

    always_comb begin
        n = s;
        if (halt) begin
            n.gate   = 1'b0;
            n.div    = 8'h00;
            n.bitCnt = 4'h0;
            n.shift  = 8'h00;
        end else if (!s.gate) begin
            if (load) begin
                n.shift  = sampleData;
                n.bitCnt = 4'h0;
                n.div    = 8'h00;
                n.gate   = 1'b1;
            end
        end else if (s.div == DIV_LAST) begin
            n.div    = 8'h00;
            n.frame  = {s.frame[10:0], s.shift[7]};      // [RULE6]
            n.shift  = {s.shift[6:0], 1'b0};             // [RULE1] [RULE2]
            n.bitCnt = s.bitCnt + 4'h1;                  // [RULE4]
            if (n.bitCnt == FRAME_END) begin
                n.gate = 1'b0;                           // [RULE4]
            end
        end else begin
            n.div = s.div + 8'h01;
        end
        // Clock rises mid-bit, so data moved at the wrap is settled at the rise
        n.sck = n.gate && (n.div >= HALF_MARK);          // [RULE3] [RULE5]
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign busy           = s.gate;
    assign frameBits      = s.frame;
    assign serialPcmClock = s.sck;
    assign serialPcmInput = s.shift[7];

    AST_GATE_CLOSED: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE5]
        !s.gate |-> !serialPcmClock)
        else $error("serial clock runs while gate is closed");

    AST_MSB_FIRST: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE2]
        (!s.gate && load && !halt) |=> serialPcmInput == $past(sampleData[7]))
        else $error("first serial bit is not the sample msb");

    AST_STOP_AT_12: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE4]
        ($fell(s.gate) && !$past(halt)) |-> s.bitCnt == FRAME_END)
        else $error("gate closed at wrong bit count");

endmodule

// *** tb/ans_codec_model.sv ***
`timescale 1ns/1ps
module ans_codec_model (
    // Clock
    input  wire logic       ref_clk,
    // Serial input of the codec
    input  wire logic       serialPcmClock,
    input  wire logic       serialPcmInput,
    // Converter
    input  wire logic       adcReadN,
    output logic            adcEndN,
    output logic [7:0]      adcData,
    // Codec outputs
    output logic            sampleRateClock,
    output logic            conversionBeginOutN,
    output logic [3:0]      nibbleDrive,
    output int              serCount,
    output logic [11:0]     frameSeen
);
    logic [7:0] convData;

    initial begin
        adcEndN = 1'b1;
        sampleRateClock = 1'b0;
        conversionBeginOutN = 1'b1;
        nibbleDrive = 4'h0;
        convData = 8'h00;
        serCount = 0;
        frameSeen = 12'h000;
    end

    // Released converter bus shows the inverse of the word
    assign adcData = adcReadN ? ~convData : convData;

    // One bit into the twelve-bit register per serial clock
    always @(posedge serialPcmClock) begin
        serCount <= serCount + 1;
        frameSeen <= {frameSeen[10:0], serialPcmInput};
    end

    // Nibble held around the sample clock, then scrambled
    task automatic sample_edge(input logic [3:0] nib, input int gap);
        @(posedge ref_clk);
        nibbleDrive <= nib;
        repeat (gap) @(posedge ref_clk);
        sampleRateClock <= 1'b1;
        repeat (gap) @(posedge ref_clk);
        sampleRateClock <= 1'b0;
        nibbleDrive <= ~nib;
        @(posedge ref_clk);
    endtask

    task automatic convert(input logic [7:0] d);
        @(posedge ref_clk);
        convData <= d;
        adcEndN <= 1'b0;
        repeat (2) @(posedge ref_clk);
        adcEndN <= 1'b1;
    endtask

    // Start of conversion pulse
    task automatic begin_conversion;
        @(posedge ref_clk);
        conversionBeginOutN <= 1'b0;
        repeat (3) @(posedge ref_clk);
        conversionBeginOutN <= 1'b1;
    endtask
endmodule

// *** tb/ans_nibble_stacker_tb_top.sv ***
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", nm, (exp), (got)); end end
module ans_nibble_stacker_tb_top;
    import ans_pkg::*;
    logic ref_clk, rstn, byteReadyIrqN, sampleRateClock, conversionBeginOutN;
    logic vocoderNibbleOeN, lowerOeN, upperOeN, anaSel, rateA, rateB, numFmt, codecReset;
    logic serClk, serDat, adcEndN, adcStartN, adcReadN, er, seen;
    logic [3:0] vocoderNibbleIn, vocoderNibbleOut, nibbleDrive;
    logic [7:0] adcData;
    logic [11:0] frameSeen;
    logic [31:0] rd;
    ans_apb_req_t apbReq;
    ans_apb_rsp_t apbRsp;
    int serCount, n0, err_total, check_count;

    // Shared nibble bus: design wins while its enable is low
    assign vocoderNibbleIn = vocoderNibbleOeN ? nibbleDrive : vocoderNibbleOut;

    always #5 ref_clk = ~ref_clk;

    ans_nibble_stacker dut_u (.ref_clk(ref_clk), .rstn(rstn), .apbReq(apbReq),
        .apbRsp(apbRsp), .byteReadyIrqN(byteReadyIrqN), .sampleRateClock(sampleRateClock),
        .conversionBeginOutN(conversionBeginOutN), .vocoderNibbleIn(vocoderNibbleIn),
        .vocoderNibbleOut(vocoderNibbleOut), .vocoderNibbleOeN(vocoderNibbleOeN),
        .lowerNibbleOutputEnableN(lowerOeN), .upperNibbleOutputEnableN(upperOeN),
        .analyzeSynthesizeSelect(anaSel), .rateSelectA(rateA), .rateSelectB(rateB),
        .numberFormatSelect(numFmt), .codecReset(codecReset), .serialPcmClock(serClk),
        .serialPcmInput(serDat), .adcEndN(adcEndN), .adcData(adcData),
        .adcStartN(adcStartN), .adcReadN(adcReadN));

    ans_codec_model partner_u (.ref_clk(ref_clk), .serialPcmClock(serClk),
        .serialPcmInput(serDat), .adcReadN(adcReadN), .adcEndN(adcEndN), .adcData(adcData),
        .sampleRateClock(sampleRateClock), .conversionBeginOutN(conversionBeginOutN),
        .nibbleDrive(nibbleDrive), .serCount(serCount), .frameSeen(frameSeen));

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge ref_clk);
        apbReq.penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk);
            if (apbRsp.pready === 1'b1) begin
                break;
            end
        end
        // Answer taken at the edge where pready is seen high
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq <= '0;
        if (n == 20) begin
            err_total++;
            print_verdict();
        end
    endtask

    task automatic wait_irq_low;
        int n;
        for (n = 0; n < 60 && byteReadyIrqN !== 1'b0; n++)
            settle(1);
        if (byteReadyIrqN !== 1'b0) begin
            err_total++;
            print_verdict();
        end
    endtask

    initial begin
        ref_clk = 1'b0;
        rstn = 1'b0;
        apbReq = '0;
        err_total = 0;
        check_count = 0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        settle(1);
        `CHK("irqN", 1'b1, byteReadyIrqN)
        `CHK("numFmt", 1'b1, numFmt)
        `CHK("rate", 2'b01, {rateA, rateB})
        apb_xfer(1'b0, OFS_LINECTL, 32'h0000_0000);
        `CHK("linectl", 32'h0000_0000, rd)
        apb_xfer(1'b0, 8'h44, 32'h0000_0000);
        `CHK("unmapped err", 1'b1, er)
        // Encode at 8 kHz
        apb_xfer(1'b1, OFS_LINECTL, 32'h0000_0003);
        settle(2);
        `CHK("ana", 1'b1, anaSel)
        `CHK("rate", 2'b10, {rateA, rateB})
        `CHK("oe", 3'b111, {lowerOeN, upperOeN, vocoderNibbleOeN})
        seen = 1'b0;
        fork
            partner_u.begin_conversion();
            repeat (12) begin
                settle(1);
                if (adcStartN === 1'b0) seen = 1'b1;
            end
        join
        `CHK("adcStart", 1'b1, seen)
        n0 = serCount;
        partner_u.convert(8'ha5);
        for (int i = 0; i < 4000 && serCount - n0 < 12; i++)
            settle(1);
        if (serCount - n0 < 12) begin
            err_total++;
            print_verdict();
        end
        settle(600);
        `CHK("serial clocks", 12, serCount - n0)
        `CHK("frame", 12'ha50, frameSeen)
        apb_xfer(1'b0, OFS_FRAME, 32'h0000_0000);
        `CHK("frame reg", 12'ha50, rd[11:0])
        partner_u.sample_edge(4'h6, 5);
        settle(2);
        apb_xfer(1'b0, OFS_STATUS, 32'h0000_0000);
        `CHK("phase", 1'b1, rd[ST_ODD])
        `CHK("irqN one nibble", 1'b1, byteReadyIrqN)
        partner_u.sample_edge(4'h9, 8);
        wait_irq_low();
        apb_xfer(1'b0, OFS_DATA, 32'h0000_0000);
        `CHK("byte", 32'h0000_0096, rd)
        apb_xfer(1'b0, OFS_STATUS, 32'h0000_0000);
        `CHK("phase", 1'b0, rd[ST_ODD])
        `CHK("irq bit", 1'b1, rd[ST_IRQ])
        apb_xfer(1'b1, OFS_DATA, 32'h0000_0000);
        settle(2);
        `CHK("irqN ack", 1'b1, byteReadyIrqN)
        // Decode at 6 kHz
        apb_xfer(1'b1, OFS_LINECTL, 32'h0000_0000);
        apb_xfer(1'b1, OFS_DATA, 32'h0000_003c);
        settle(2);
        `CHK("rate", 2'b01, {rateA, rateB})
        `CHK("low", 7'b0_0_1_1100, {vocoderNibbleOeN, lowerOeN, upperOeN, vocoderNibbleOut})
        partner_u.sample_edge(4'h0, 5);
        settle(1);
        `CHK("high", 6'b0_0011, {upperOeN, vocoderNibbleOut})
        apb_xfer(1'b1, OFS_DATA, 32'h0000_0077);
        settle(2);
        `CHK("held", 4'h3, vocoderNibbleOut)
        apb_xfer(1'b0, OFS_STATUS, 32'h0000_0000);
        `CHK("pend", 1'b1, rd[ST_PEND])
        partner_u.sample_edge(4'h0, 6);
        wait_irq_low();
        settle(1);
        `CHK("next low", 5'b0_0111, {lowerOeN, vocoderNibbleOut})
        // Halt
        apb_xfer(1'b1, OFS_LINECTL, 32'h0000_0021);
        partner_u.convert(8'h5a);
        settle(10);
        `CHK("codecReset", 1'b1, codecReset)
        `CHK("adcReadN", 1'b1, adcReadN)
        print_verdict();
    end
endmodule
